//--- bench/atm_cell_port_tb.sv
// self-checking bench of the cell port: rx fill and drain, tx cells, mii status
`timescale 1ns/1ps
`default_nettype none
module atm_cell_port_tb;
  import atm_port_pkg::*;
  byte_beat_t  wr_beat, tx_beat;
  mii_status_t mii_pins;
  logic [7:0]  rx_data, tx_data, rx_pin, last_pin, exp_b [0:52];
  logic        sys_clk, rst, wr_valid, wr_ready, rx_enb, rx_data_oe, rx_soc, rx_clav;
  logic        tx_valid, tx_ready, tx_soc, tx_en, tx_clav, tx_underrun;
  logic        broken_hdr, frame_err, stall, arm;
  logic [31:0] lfsr = 32'h146262fb;
  int          err_count = 0;
  int          checked = 0;

  atm_cell_port uut (.sys_clk(sys_clk), .rst(rst), .wr_beat(wr_beat), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rx_enb(rx_enb), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
    .rx_soc(rx_soc), .rx_clav(rx_clav), .tx_beat(tx_beat), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_soc(tx_soc), .tx_en(tx_en), .tx_clav(tx_clav),
    .tx_underrun(tx_underrun), .mii_pins(mii_pins), .broken_hdr(broken_hdr),
    .frame_err(frame_err));
  utopia_master_model master (.sys_clk(sys_clk), .rst(rst), .stall(stall), .arm(arm),
    .rx_pin(rx_pin), .rx_data_oe(rx_data_oe), .rx_soc(rx_soc), .rx_clav(rx_clav),
    .rx_enb(rx_enb));

  // a released bus must not look like the last octet
  assign rx_pin = rx_data_oe ? rx_data : ~last_pin;
  always @(posedge sys_clk) last_pin <= rst ? 8'h00 : rx_data_oe ? rx_data : last_pin;

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  function automatic logic [7:0] idle_byte(input int k);
    return k < 3 ? 8'h00 : k == 3 ? 8'h01 : k == 4 ? 8'h52 : 8'h6a;
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic fill_rx;
    for (int k = 0; k < 53; k++) begin
      exp_b[k] = rnd();
      if (k == 52) cmp1(rx_clav, 1'b0);
      wr_beat = {k == 0, exp_b[k]};
      wr_valid = 1'b1;
      while (!wr_ready) step;
      step;
      if (rnd() < 8'h50) begin
        wr_valid = 1'b0;
        step;
      end
    end
    wr_valid = 1'b0;
    cmp1(rx_clav, 1'b1);
    cmp1(wr_ready, 1'b0);
  endtask

  task automatic drain_rx;
    arm = 1'b1;
    step;
    arm = 1'b0;
    for (int n = 0; n < 600 && master.cnt < 53; n++) begin
      stall = rnd() < 8'h50;
      step;
    end
    stall = 1'b0;
    for (int k = 0; k < 53; k++) cmp8(master.cap[k], exp_b[k]);
    repeat (6) step;
    cmp1(rx_clav, 1'b0);
    cmp1(wr_ready, 1'b1);
    cmp1(rx_data_oe, 1'b0);
  endtask

  // sof offered in the cycle where tx_clav shows; octets past nv run dry
  task automatic tx_cell(input int nv, input logic sof);
    logic [7:0] d [0:53];
    logic       seen;
    seen = 1'b0;
    for (int n = 0; n < 60 && tx_clav !== 1'b1; n++) step;
    for (int k = 0; k <= 53; k++) begin
      if (k > 0) begin
        cmp8(tx_data, (sof && k <= nv) ? d[k-1] : (sof && nv > 0) ? 8'h6a : idle_byte(k-1));
        cmp1(tx_soc, k == 1);
        cmp1(tx_en, 1'b1);
        cmp1(tx_ready, 1'b1);
        cmp1(tx_clav, k == 53);
        seen |= tx_underrun;
      end
      d[k] = rnd();
      tx_valid = k < nv;
      tx_beat = {sof && k == 0, d[k]};
      step;
    end
    tx_valid = 1'b0;
    cmp1(seen, sof && nv > 0 && nv < 53);
  endtask

  task automatic report_and_stop;
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #(6000 * 50);
    err_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    {wr_valid, tx_valid, stall, arm} = 4'h0;
    wr_beat = '0;
    tx_beat = '0;
    mii_pins = '0;
    repeat (5) step;
    cmp1(tx_en, 1'b0);
    cmp1(rx_clav, 1'b0);
    rst = 1'b0;
    tx_cell(0, 1'b0);
    fill_rx();
    drain_rx();
    fill_rx();
    drain_rx();
    tx_cell(53, 1'b1);
    tx_cell(53, 1'b1);
    tx_cell(53, 1'b0);
    tx_cell(20, 1'b1);
    for (int c = 0; c < 8; c++) begin
      mii_pins = c[2:0];
      repeat (4) step;
      cmp1(broken_hdr, c[2] && !c[1]);
      cmp1(frame_err, c[0] && c[1]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- bench/utopia_master_model.sv
// receive-side utopia master model: pulls one cell over rx_enb, pausing at random
`timescale 1ns/1ps
`default_nettype none
module utopia_master_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       arm,
  input  wire logic [7:0] rx_pin,
  input  wire logic       rx_data_oe,
  input  wire logic       rx_soc,
  input  wire logic       rx_clav,
  output logic            rx_enb
);
  logic [7:0] cap [0:52];
  int         cnt = 53;

  // enable only while a cell is offered or under way; a stall pauses the cell
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_enb <= 1'b0;
    end else begin
      rx_enb <= #1 !stall && (rx_clav || (cnt > 0 && cnt < 53));
    end
  end

  // octets count only in cycles where the port drives the bus
  always @(posedge sys_clk) begin
    if (arm) begin
      cnt <= 0;
    end else if (rx_data_oe && rx_soc) begin
      cap[0] <= rx_pin;
      cnt <= 1;
    end else if (rx_data_oe && cnt > 0 && cnt < 53) begin
      cap[cnt] <= rx_pin;
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- design/atm_cell_port.sv
// cell port of fast_comm_ctrl_one: utopia slave receive, idle-filling transmit, mii status
//
// Notes on behaviour
// - rx start-of-cell is high while the rx bus carries a cell's first octet
// - rx cell-available is high only when one whole cell is stored
// - transmit octets go out on eight bits, bit 0 least significant
// - with no user cell queued, idle cells are sent
// - every cell is exactly 53 octets on both sides
// - carrier sense without data valid means broken packet headers
// - rx octet and start-of-cell are valid the third cycle after enable (two synchroniser stages, then the output register)
// - tx cell-available is high only when a whole cell can be taken
// - rx octet bus is driven only after receive enable, else released
`timescale 1ns/1ps
`default_nettype none
`include "atm_port_cfg.svh"
module atm_cell_port #(
  parameter int CELL_LEN = `CELL_LEN,
  parameter int DEPTH    = `STORE_DEPTH
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire atm_port_pkg::byte_beat_t  wr_beat,
  input  wire logic                      wr_valid,
  output logic                           wr_ready,
  input  wire logic                      rx_enb,
  output logic [`OCTET_W-1:0]            rx_data,
  output logic                           rx_data_oe,
  output logic                           rx_soc,
  output logic                           rx_clav,
  input  wire atm_port_pkg::byte_beat_t  tx_beat,
  input  wire logic                      tx_valid,
  output logic                           tx_ready,
  output logic [`OCTET_W-1:0]            tx_data,
  output logic                           tx_soc,
  output logic                           tx_en,
  output logic                           tx_clav,
  output logic                           tx_underrun,
  input  wire atm_port_pkg::mii_status_t mii_pins,
  output logic                           broken_hdr,
  output logic                           frame_err
);
  import atm_port_pkg::*;

  localparam logic [`CELL_IDX_W-1:0] LAST_IDX = `CELL_IDX_W'(CELL_LEN - 1);

  // refused at elaboration: the octet index is only as wide as the store address
  if (CELL_LEN <= `HDR_LEN || CELL_LEN > DEPTH || DEPTH > (1 << `CELL_IDX_W)) begin : g_bad_len
    $error("atm_cell_port: cell length does not fit the store");
  end

  // pin synchronisers; only the second stage is read
  logic        enb_s1_q, enb_s2_q;
  mii_status_t mii_s1_q, mii_s2_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enb_s1_q <= 1'b0;
      enb_s2_q <= 1'b0;
      mii_s1_q <= '0;
      mii_s2_q <= '0;
    end else begin
      enb_s1_q <= rx_enb;
      enb_s2_q <= enb_s1_q;
      mii_s1_q <= mii_pins;
      mii_s2_q <= mii_s1_q;
    end
  end

  // receive: user fills one cell, the phy master drains it
  logic [`CELL_IDX_W-1:0] wr_idx_q, wr_addr, rd_idx_q, rd_idx_d;
  logic [`OCTET_W-1:0]    mem_q;
  logic                   full_q, full_d, wr_fire, take, last;

  assign wr_fire = wr_valid && wr_ready;
  assign wr_addr = wr_beat.sof ? `IDX_ZERO : wr_idx_q;
  assign take    = enb_s2_q && full_q;
  assign last    = (rd_idx_q == LAST_IDX);

  always_comb begin
    rd_idx_d = rd_idx_q;
    if (take) begin
      rd_idx_d = last ? `IDX_ZERO : rd_idx_q + `IDX_ONE;
    end
    full_d = (full_q && !(take && last)) || (wr_fire && wr_addr == LAST_IDX);
  end

  // read address runs on the next index so the octet is ready one cycle early
  cell_store #(
    .WIDTH (`OCTET_W),
    .DEPTH (DEPTH),
    .AW    (`CELL_IDX_W)
  ) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .wr_en   (wr_fire),
    .wr_addr (wr_addr),
    .wr_data (wr_beat.data),
    .rd_addr (rd_idx_d),
    .rd_data (mem_q)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_idx_q <= `IDX_ZERO;
      full_q   <= 1'b0;
      rd_idx_q <= `IDX_ZERO;
      wr_ready <= 1'b0;
      rx_clav  <= 1'b0;
    end else begin
      if (wr_fire) begin
        wr_idx_q <= (wr_addr == LAST_IDX) ? `IDX_ZERO : wr_addr + `IDX_ONE;
      end
      full_q   <= full_d;
      rd_idx_q <= rd_idx_d;
      // single cell store: no writes until the stored cell has left
      wr_ready <= !full_d;
      rx_clav  <= full_d && rd_idx_d == `IDX_ZERO;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_data    <= `OCTET_ZERO;
      rx_soc     <= 1'b0;
      rx_data_oe <= 1'b0;
    end else begin
      rx_data    <= take ? mem_q : `OCTET_ZERO;
      rx_soc     <= take && rd_idx_q == `IDX_ZERO;
      rx_data_oe <= enb_s2_q;
    end
  end

  // transmit: user cells when offered at a boundary, else idle cells
  tx_src_t                src_q, src_d;
  logic [`CELL_IDX_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [`OCTET_W-1:0]    idle_oct, tx_oct;
  logic                   user_oct;

  always_comb begin
    unique case (tx_cnt_q)
      `CELL_IDX_W'(0): idle_oct = `IDLE_HDR0;
      `CELL_IDX_W'(1): idle_oct = `IDLE_HDR1;
      `CELL_IDX_W'(2): idle_oct = `IDLE_HDR2;
      `CELL_IDX_W'(3): idle_oct = `IDLE_HDR3;
      `CELL_IDX_W'(4): idle_oct = `IDLE_HEC;
      default:         idle_oct = `IDLE_PAYLOAD;
    endcase
  end

  always_comb begin
    src_d = src_q;
    if (tx_cnt_q == `IDX_ZERO) begin
      src_d = (tx_valid && tx_beat.sof) ? SRC_USER : SRC_IDLE;
    end
    user_oct = (src_d == SRC_USER) && tx_valid;
    // a dry user cell is padded with payload octets, never with idle header octets
    tx_oct   = user_oct ? tx_beat.data : (src_d == SRC_USER) ? `IDLE_PAYLOAD : idle_oct;
    tx_cnt_d = (tx_cnt_q == LAST_IDX) ? `IDX_ZERO : tx_cnt_q + `IDX_ONE;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      src_q       <= SRC_IDLE;
      tx_cnt_q    <= `IDX_ZERO;
      tx_data     <= `OCTET_ZERO;
      tx_soc      <= 1'b0;
      tx_en       <= 1'b0;
      tx_ready    <= 1'b0;
      tx_clav     <= 1'b0;
      tx_underrun <= 1'b0;
    end else begin
      src_q       <= src_d;
      tx_cnt_q    <= tx_cnt_d;
      tx_data     <= tx_oct;
      tx_soc      <= (tx_cnt_q == `IDX_ZERO);
      tx_en       <= 1'b1;
      // the line drains one octet each cycle, so the user side never waits
      tx_ready    <= 1'b1;
      tx_clav     <= (tx_cnt_d == `IDX_ZERO);
      // a user cell that runs dry mid-cell is padded with idle payload
      tx_underrun <= (src_d == SRC_USER) && !tx_valid && tx_cnt_q != `IDX_ZERO;
    end
  end

  // mii receive status
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      broken_hdr <= 1'b0;
      frame_err  <= 1'b0;
    end else begin
      broken_hdr <= mii_s2_q.crs && !mii_s2_q.dv;
      frame_err  <= mii_s2_q.er && mii_s2_q.dv;
    end
  end

  // checks
  localparam int CELL_DLY = CELL_LEN;
  localparam int HDR_W    = `HDR_LEN;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_soc_first: assert property (rx_soc |-> rx_data_oe && $past(rd_idx_q) == `IDX_ZERO)
    else $error("rx start-of-cell not on first octet");
  chk_clav_full: assert property (rx_clav |-> full_q && rd_idx_q == `IDX_ZERO)
    else $error("rx cell-available without a whole cell");
  chk_bit_order: assert property (user_oct |=> tx_data == $past(tx_beat.data))
    else $error("tx octet altered");
  chk_idle_fill: assert property (tx_cnt_q == `IDX_ZERO && !(tx_valid && tx_beat.sof)
                                  |=> tx_soc && tx_data == `IDLE_HDR0 ##HDR_W tx_data == `IDLE_PAYLOAD)
    else $error("idle cell not inserted");
  chk_cell_len: assert property (tx_soc |-> ##[CELL_DLY:CELL_DLY] tx_soc)
    else $error("tx cell length wrong");
  chk_hdr_broken: assert property (mii_s2_q.crs && !mii_s2_q.dv |=> broken_hdr)
    else $error("broken header not flagged");
  chk_rx_timing: assert property (take |=> rx_data_oe && rx_data == $past(mem_q))
    else $error("rx octet not presented after enable");
  chk_tx_clav: assert property (tx_clav |=> tx_soc)
    else $error("tx cell-available off a boundary");
  chk_bus_release: assert property (!$past(enb_s2_q) |-> !rx_data_oe)
    else $error("rx bus driven without enable");
  chk_burst_step: assert property (take && !last |=> full_q && rd_idx_q == $past(rd_idx_q) + `IDX_ONE)
    else $error("rx octet index did not advance");

  cov_cell_out:  cover property (take && last);
  cov_idle_cell: cover property (tx_soc && src_q == SRC_IDLE);
  cov_user_cell: cover property (tx_soc && src_q == SRC_USER);
  cov_broken:    cover property (broken_hdr);
endmodule
`default_nettype wire

//--- design/cell_store.sv
// one-cell octet store with registered read data
`timescale 1ns/1ps
`default_nettype none
module cell_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // refused at elaboration: rows past the address range could never be read
  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("cell_store: depth does not fit address width");
  end

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- pkg/atm_port_cfg.svh
// constants of the cell port: cell geometry, idle cell bytes, widths
`ifndef ATM_PORT_CFG_SVH
`define ATM_PORT_CFG_SVH
`define CELL_LEN      53
`define CELL_IDX_W    6
`define STORE_DEPTH   64
`define OCTET_W       8
`define HDR_LEN       5
`define IDLE_HDR0     8'h00
`define IDLE_HDR1     8'h00
`define IDLE_HDR2     8'h00
`define IDLE_HDR3     8'h01
`define IDLE_HEC      8'h52
`define IDLE_PAYLOAD  8'h6a
`define IDX_ZERO      6'h00
`define IDX_ONE       6'h01
`define OCTET_ZERO    8'h00
`endif

//--- pkg/atm_port_pkg.sv
// types shared by the cell port and its bench
`default_nettype none
package atm_port_pkg;
  typedef struct packed {
    logic       sof;
    logic [7:0] data;
  } byte_beat_t;

  typedef struct packed {
    logic crs;
    logic dv;
    logic er;
  } mii_status_t;

  typedef enum logic {
    SRC_IDLE,
    SRC_USER
  } tx_src_t;
endpackage
`default_nettype wire
